//--- mbdo_observer.sv
// Purpose: Debug address, memory-valid strobe, fault injection and error capture
// Assumes: All inputs synchronous to ref_clk
// Notes:   Control bits are plain ports; no software bus
`timescale 1ns/10ps
module mbdo_observer (
   // Clock and reset
   input  wire logic                         ref_clk,
   input  wire logic                         reset,
   // Control
   input  wire logic                         dbg_addr_enable,
   input  wire logic                         capture_rearm,
   input  wire mbdo_pkg::mbdo_fault_type     fault_req,
   // Memory controller cycle
   input  wire mbdo_pkg::mbdo_cycle_type     cycle_in,
   // Data paths and checker
   input  wire mbdo_pkg::mbdo_dpath_type     int_path_in,
   input  wire mbdo_pkg::mbdo_dpath_type     mem_path_in,
   input  wire logic                         check_error,
   // Debug outputs
   output logic [mbdo_pkg::DBG_AW-1:0]       dbg_addr,
   output logic                              memory_cycle_valid_n,
   output mbdo_pkg::mbdo_dpath_type          int_path_out,
   output mbdo_pkg::mbdo_dpath_type          mem_path_out,
   output mbdo_pkg::mbdo_dpath_type          capture_data,
   output logic                              capture_valid
);
   //------------------------------------------------------------
   // Debug address selection
   //------------------------------------------------------------
   mbdo_pkg::mbdo_cycle_type cyc;
   assign cyc = cycle_in;

   wire is_dram = (cyc.kind == mbdo_pkg::MBDO_CYC_FPM) || (cyc.kind == mbdo_pkg::MBDO_CYC_EDO)
                  || (cyc.kind == mbdo_pkg::MBDO_CYC_SDRAM);
   wire is_rom  = (cyc.kind == mbdo_pkg::MBDO_CYC_ROM) || (cyc.kind == mbdo_pkg::MBDO_CYC_FLASH)
                  || (cyc.kind == mbdo_pkg::MBDO_CYC_EXPIO);

   // Address in interface units: drop byte lanes below the bus width
   function automatic logic [mbdo_pkg::PHYS_AW-1:0] unit_addr(
      input logic [mbdo_pkg::PHYS_AW-1:0] a,
      input mbdo_pkg::mbdo_width_type     w);
      case (w)
         mbdo_pkg::MBDO_W64: unit_addr = {3'h0, a[mbdo_pkg::PHYS_AW-1:3]};
         mbdo_pkg::MBDO_W32: unit_addr = {2'h0, a[mbdo_pkg::PHYS_AW-1:2]};
         default:            unit_addr = a;
      endcase
   endfunction : unit_addr

   wire [mbdo_pkg::PHYS_AW-1:0] unit_a = unit_addr(cyc.phys_addr, cyc.width);
   // DRAM: upper bits beyond the row/column pins; ROM: top 16 bits of the 24-bit ROM address
   wire [mbdo_pkg::DBG_AW-1:0] dram_dbg =
      unit_a[mbdo_pkg::PHYS_AW-1:mbdo_pkg::PHYS_AW-mbdo_pkg::DBG_AW];
   wire [mbdo_pkg::DBG_AW-1:0] rom_dbg  =
      unit_a[mbdo_pkg::ROM_AW-1:mbdo_pkg::ROM_AW-mbdo_pkg::DBG_AW];
   wire load_dram = dbg_addr_enable && is_dram && cyc.col_phase;
   wire load_rom  = dbg_addr_enable && is_rom && cyc.rom_phase;
   wire [mbdo_pkg::DBG_AW-1:0] dbg_d = load_dram ? dram_dbg
                                     : load_rom ? rom_dbg
                                     : dbg_addr_enable ? dbg_addr : '0;

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         dbg_addr <= '0;
      end else begin
         dbg_addr <= dbg_d;
      end
   end

   //------------------------------------------------------------
   // Memory-valid strobe
   //------------------------------------------------------------
   wire valid_n_d = ~((is_dram || cyc.kind == mbdo_pkg::MBDO_CYC_ROM
                       || cyc.kind == mbdo_pkg::MBDO_CYC_FLASH)
                      && (cyc.addr_present || cyc.data_present));

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         memory_cycle_valid_n <= mbdo_pkg::VLDN_RESET;
      end else begin
         memory_cycle_valid_n <= valid_n_d;
      end
   end

   //------------------------------------------------------------
   // Fault injection
   //------------------------------------------------------------
   function automatic mbdo_pkg::mbdo_dpath_type stuck(
      input mbdo_pkg::mbdo_dpath_type v,
      input mbdo_pkg::mbdo_dpath_type m,
      input mbdo_pkg::mbdo_dpath_type s,
      input logic                     on);
      stuck = on ? ((v & ~m) | (s & m)) : v;
   endfunction : stuck

   wire inj_int = fault_req.enable && !fault_req.to_memory;
   wire inj_mem = fault_req.enable && fault_req.to_memory;
   mbdo_pkg::mbdo_dpath_type int_d;
   mbdo_pkg::mbdo_dpath_type mem_d;
   assign int_d = stuck(int_path_in, fault_req.stuck_mask, fault_req.stuck_val, inj_int);
   assign mem_d = stuck(mem_path_in, fault_req.stuck_mask, fault_req.stuck_val, inj_mem);

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         int_path_out <= '0;
         mem_path_out <= '0;
      end else begin
         int_path_out <= int_d;
         mem_path_out <= mem_d;
      end
   end

   //------------------------------------------------------------
   // Error capture
   //------------------------------------------------------------
   wire take = check_error && (!capture_valid || capture_rearm);
   // Error beats the re-arm in the same cycle
   wire cap_valid_d = take ? 1'b1 : (capture_rearm ? 1'b0 : capture_valid);

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         capture_valid <= 1'b0;
         capture_data  <= '0;
      end else begin
         capture_valid <= cap_valid_d;
         if (take) begin
            capture_data <= mem_d;
         end
      end
   end

   //------------------------------------------------------------
   // Assertions
   //------------------------------------------------------------
   sequence s_err_taken;
      check_error && (!capture_valid || capture_rearm);
   endsequence

   property p_capture;
      @(posedge ref_clk) disable iff (reset)
      s_err_taken |=> capture_valid && (capture_data == $past(mem_d));
   endproperty
   a_capture: assert property (p_capture) else $error("capture missed");

   property p_hold;
      @(posedge ref_clk) disable iff (reset)
      capture_valid && !capture_rearm |=> capture_valid && $stable(capture_data);
   endproperty
   a_hold: assert property (p_hold) else $error("capture overwritten");

   property p_strobe_on;
      @(posedge ref_clk) disable iff (reset)
      (is_dram && cyc.data_present) |=> !memory_cycle_valid_n;
   endproperty
   a_strobe_on: assert property (p_strobe_on) else $error("valid strobe missing");

   property p_strobe_idle;
      @(posedge ref_clk) disable iff (reset)
      (cyc.kind == mbdo_pkg::MBDO_CYC_IDLE) |=> memory_cycle_valid_n;
   endproperty
   a_strobe_idle: assert property (p_strobe_idle) else $error("strobe in idle");

   property p_strobe_absent;
      @(posedge ref_clk) disable iff (reset)
      !(cyc.addr_present || cyc.data_present) |=> memory_cycle_valid_n;
   endproperty
   a_strobe_absent: assert property (p_strobe_absent) else $error("bus empty strobe");

   property p_expio_quiet;
      @(posedge ref_clk) disable iff (reset)
      (cyc.kind == mbdo_pkg::MBDO_CYC_EXPIO) |=> memory_cycle_valid_n;
   endproperty
   a_expio_quiet: assert property (p_expio_quiet) else $error("strobe on port");

   property p_dram_addr;
      @(posedge ref_clk) disable iff (reset)
      load_dram |=> dbg_addr == $past(dram_dbg);
   endproperty
   a_dram_addr: assert property (p_dram_addr) else $error("dram debug addr");

   property p_rom_addr;
      @(posedge ref_clk) disable iff (reset)
      load_rom |=> dbg_addr == $past(rom_dbg);
   endproperty
   a_rom_addr: assert property (p_rom_addr) else $error("rom debug addr");

   property p_off;
      @(posedge ref_clk) disable iff (reset)
      !dbg_addr_enable |=> dbg_addr == '0;
   endproperty
   a_off: assert property (p_off) else $error("debug addr not off");

   // Double-word units: top physical bits shifted down by three
   wire [mbdo_pkg::DBG_AW-1:0] w64_ref =
      {3'h0, cyc.phys_addr[mbdo_pkg::PHYS_AW-1:mbdo_pkg::PHYS_AW-mbdo_pkg::DBG_AW+3]};

   property p_w64;
      @(posedge ref_clk) disable iff (reset)
      load_dram && cyc.width == mbdo_pkg::MBDO_W64 |=> dbg_addr == $past(w64_ref);
   endproperty
   a_w64: assert property (p_w64) else $error("width scaling");

   property p_addr_hold;
      @(posedge ref_clk) disable iff (reset)
      dbg_addr_enable && !load_dram && !load_rom |=> $stable(dbg_addr);
   endproperty
   a_addr_hold: assert property (p_addr_hold) else $error("debug addr drifted");

   property p_noinj;
      @(posedge ref_clk) disable iff (reset)
      !fault_req.enable |=> int_path_out == $past(int_path_in)
                            && mem_path_out == $past(mem_path_in);
   endproperty
   a_noinj: assert property (p_noinj) else $error("path altered");

   property p_inj_target;
      @(posedge ref_clk) disable iff (reset)
      inj_mem |=> int_path_out == $past(int_path_in);
   endproperty
   a_inj_target: assert property (p_inj_target) else $error("wrong path faulted");

   sequence s_rearm_only;
      capture_rearm && !check_error;
   endsequence

   property p_rearm;
      @(posedge ref_clk) disable iff (reset)
      s_rearm_only |=> !capture_valid;
   endproperty
   a_rearm: assert property (p_rearm) else $error("capture not re-armed");
endmodule : mbdo_observer

//--- mbdo_pkg.sv
// Purpose: Shared types and constants for the memory bus debug observer
// Assumes: Single peripheral bus clock domain
// Notes:   Physical addresses are 30 bits wide
package mbdo_pkg;
   localparam int unsigned PHYS_AW    = 30;
   localparam int unsigned DBG_AW     = 16;
   localparam int unsigned ROM_AW     = 24;
   localparam int unsigned DATA_W     = 64;
   localparam int unsigned PAR_W      = 8;
   localparam logic        VLDN_RESET = 1'b1;

   // Memory cycle kinds seen on the external bus
   typedef enum logic [2:0] {
      MBDO_CYC_IDLE  = 3'b000,
      MBDO_CYC_FPM   = 3'b001,
      MBDO_CYC_EDO   = 3'b010,
      MBDO_CYC_SDRAM = 3'b011,
      MBDO_CYC_ROM   = 3'b100,
      MBDO_CYC_FLASH = 3'b101,
      MBDO_CYC_EXPIO = 3'b110
   } mbdo_cyc_type;

   // Interface width of the cycle
   typedef enum logic [1:0] {
      MBDO_W8  = 2'b00,
      MBDO_W32 = 2'b01,
      MBDO_W64 = 2'b10
   } mbdo_width_type;

   // Memory controller view of one bus cycle
   typedef struct packed {
      mbdo_cyc_type              kind;
      mbdo_width_type            width;
      logic                      col_phase;
      logic                      rom_phase;
      logic                      addr_present;
      logic                      data_present;
      logic [PHYS_AW-1:0]        phys_addr;
   } mbdo_cycle_type;

   // Data path word with parity
   typedef struct packed {
      logic [DATA_W-1:0] data;
      logic [PAR_W-1:0]  par;
   } mbdo_dpath_type;

   // Stuck-at fault request
   typedef struct packed {
      logic           enable;
      logic           to_memory;
      mbdo_dpath_type stuck_mask;
      mbdo_dpath_type stuck_val;
   } mbdo_fault_type;
endpackage : mbdo_pkg

//--- mbdo_trace_model.sv
// Purpose: Trace tool model watching the debug outputs
// Assumes: Strobe active low, sampled on ref_clk
// Notes:   Counts strobed cycles and keeps the last address seen
`timescale 1ns/10ps
module mbdo_trace_model (
   // Clock and reset
   input  wire logic                        ref_clk,
   input  wire logic                        reset,
   // Observed debug bus
   input  wire logic [mbdo_pkg::DBG_AW-1:0] dbg_addr,
   input  wire logic                        memory_cycle_valid_n,
   // Trace results
   output logic [15:0]                      strobe_count,
   output logic [mbdo_pkg::DBG_AW-1:0]      last_addr
);
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         strobe_count <= 16'h0000;
         last_addr    <= 16'h0000;
      end else if (!memory_cycle_valid_n) begin
         strobe_count <= strobe_count + 16'h0001;
         last_addr    <= dbg_addr;
      end
   end
endmodule : mbdo_trace_model

//--- tb_top.sv
// Purpose: Self-checking bench for the memory bus debug observer
// Assumes: 250 MHz ref_clk, outputs one cycle after inputs
// Notes:   Trace model counts strobed cycles
`timescale 1ns/10ps
module tb_top;
   logic                     ref_clk, reset, dbg_addr_enable, capture_rearm, check_error;
   logic                     memory_cycle_valid_n, capture_valid;
   logic [15:0]              dbg_addr, strobe_count, exp_addr, last_addr;
   mbdo_pkg::mbdo_fault_type fault_req;
   mbdo_pkg::mbdo_cycle_type cycle_in;
   mbdo_pkg::mbdo_dpath_type int_path_in, mem_path_in, int_path_out, mem_path_out, capture_data;
   int                       failures, total_checks, cycles, exp_strobes;

   mbdo_observer i_mbdo_observer (.ref_clk, .reset, .dbg_addr_enable, .capture_rearm,
      .fault_req, .cycle_in, .int_path_in, .mem_path_in, .check_error, .dbg_addr,
      .memory_cycle_valid_n, .int_path_out, .mem_path_out, .capture_data, .capture_valid);
   mbdo_trace_model i_mbdo_trace_model (.ref_clk, .reset, .dbg_addr, .memory_cycle_valid_n,
      .strobe_count, .last_addr);

   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end

   task automatic chk(input string name, input logic [71:0] exp, input logic [71:0] got);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   task automatic stop_test;
      if (failures == 0 && total_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : stop_test

   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 1000) begin
         failures++;
         stop_test();
      end
   end

   task automatic run_cycle(input mbdo_pkg::mbdo_cyc_type k, input mbdo_pkg::mbdo_width_type w,
                            input logic en, input logic [29:0] a);
      logic [29:0] u;
      logic        dram;
      logic        strb;
      dram = k inside {mbdo_pkg::MBDO_CYC_FPM, mbdo_pkg::MBDO_CYC_EDO, mbdo_pkg::MBDO_CYC_SDRAM};
      strb = dram || k inside {mbdo_pkg::MBDO_CYC_ROM, mbdo_pkg::MBDO_CYC_FLASH};
      u    = (w == mbdo_pkg::MBDO_W64) ? a >> 3 : (w == mbdo_pkg::MBDO_W32) ? a >> 2 : a;
      if (k != mbdo_pkg::MBDO_CYC_IDLE) begin
         exp_addr = dram ? u[29:14] : u[23:8];
      end
      if (!en) begin
         exp_addr = 16'h0000;
      end
      exp_strobes += strb;
      @(posedge ref_clk);
      cycle_in        <= '{kind: k, width: w, col_phase: dram, rom_phase: !dram,
                           addr_present: (w != mbdo_pkg::MBDO_W64),
                           data_present: (w != mbdo_pkg::MBDO_W8), phys_addr: a};
      dbg_addr_enable <= en;
      @(posedge ref_clk);
      cycle_in        <= '0;
      #1;
      chk("dbg_addr", exp_addr, dbg_addr);
      chk("valid_n", !strb, memory_cycle_valid_n);
      @(posedge ref_clk);
      #1;
      chk("dbg_addr_hold", exp_addr, dbg_addr);
      chk("valid_n_idle", 1'b1, memory_cycle_valid_n);
      if (strb) begin
         chk("trace_addr", exp_addr, last_addr);
      end
   endtask : run_cycle

   task automatic test_addr;
      for (int i = 0; i < 7; i++) begin
         for (int j = 0; j < 3; j++) begin
            run_cycle(mbdo_pkg::mbdo_cyc_type'(i), mbdo_pkg::mbdo_width_type'(j), 1'b1,
                      30'h2b5ac3e7 + 30'(i * 3 + j) * 30'h01234567);
         end
      end
      run_cycle(mbdo_pkg::MBDO_CYC_SDRAM, mbdo_pkg::MBDO_W8, 1'b1, 30'h3fffffff);
      run_cycle(mbdo_pkg::MBDO_CYC_SDRAM, mbdo_pkg::MBDO_W64, 1'b0, 30'h3fffffff);
   endtask : test_addr

   task automatic test_no_strobe;
      @(posedge ref_clk);
      cycle_in <= '{kind: mbdo_pkg::MBDO_CYC_SDRAM, width: mbdo_pkg::MBDO_W32, col_phase: 1'b0,
                    rom_phase: 1'b0, addr_present: 1'b0, data_present: 1'b0, phys_addr: 30'h0};
      @(posedge ref_clk);
      cycle_in <= '0;
      #1;
      chk("valid_n_absent", 1'b1, memory_cycle_valid_n);
   endtask : test_no_strobe

   task automatic test_fault;
      mbdo_pkg::mbdo_dpath_type m, v, x;
      m = {64'hff00_0000_0000_00f0, 8'h81};
      v = {64'h5a00_0000_0000_00a0, 8'h01};
      x = {64'h0123_4567_89ab_cdef, 8'h3c};
      @(posedge ref_clk);
      int_path_in <= x;
      mem_path_in <= ~x;
      @(posedge ref_clk);
      #1;
      chk("int_path", x, int_path_out);
      chk("mem_path", ~x, mem_path_out);
      for (int p = 0; p < 2; p++) begin
         @(posedge ref_clk);
         fault_req <= '{enable: 1'b1, to_memory: p[0], stuck_mask: m, stuck_val: v};
         @(posedge ref_clk);
         #1;
         chk("int_path", p ? x : (x & ~m) | (v & m), int_path_out);
         chk("mem_path", p ? (~x & ~m) | (v & m) : ~x, mem_path_out);
      end
      @(posedge ref_clk);
      fault_req <= '0;
   endtask : test_fault

   task automatic test_capture;
      mbdo_pkg::mbdo_dpath_type d [3];
      d = '{{64'hdead_beef_0bad_f00d, 8'h5a}, {64'h1111_2222_3333_4444, 8'ha5},
            {64'hcafe_0000_ffff_1234, 8'h0f}};
      for (int i = 0; i < 3; i++) begin
         @(posedge ref_clk);
         mem_path_in   <= d[i];
         check_error   <= 1'b1;
         capture_rearm <= 1'b0;
         @(posedge ref_clk);
         check_error   <= 1'b0;
         capture_rearm <= (i == 1);
         #1;
         chk("cap_valid", 1'b1, capture_valid);
         chk("cap_data", (i == 2) ? d[2] : d[0], capture_data);
      end
      @(posedge ref_clk);
      mem_path_in   <= d[1];
      check_error   <= 1'b1;
      capture_rearm <= 1'b1;
      @(posedge ref_clk);
      check_error   <= 1'b0;
      #1;
      chk("cap_same_valid", 1'b1, capture_valid);
      chk("cap_same_data", d[1], capture_data);
      @(posedge ref_clk);
      capture_rearm <= 1'b0;
      #1;
      chk("cap_rearm", 1'b0, capture_valid);
   endtask : test_capture

   task automatic test_reset;
      @(posedge ref_clk);
      mem_path_in <= {64'h0f0f_0000_a5a5_0001, 8'h77};
      int_path_in <= '0;
      check_error <= 1'b1;
      @(posedge ref_clk);
      check_error <= 1'b0;
      mem_path_in <= '0;
      #1;
      chk("cap_before_rst", 1'b1, capture_valid);
      @(posedge ref_clk);
      reset <= 1'b1;
      @(posedge ref_clk);
      reset <= 1'b0;
      #1;
      chk("rst_mid_cap", 1'b0, capture_valid);
      chk("rst_mid_data", 72'h0, capture_data);
      chk("rst_mid_valid_n", 1'b1, memory_cycle_valid_n);
      chk("rst_mid_dbg", 16'h0000, dbg_addr);
   endtask : test_reset

   initial begin
      reset           = 1'b1;
      dbg_addr_enable = 1'b0;
      capture_rearm   = 1'b0;
      check_error     = 1'b0;
      fault_req       = '0;
      cycle_in        = '0;
      int_path_in     = '0;
      mem_path_in     = '0;
      exp_addr        = 16'h0000;
      repeat (4) @(posedge ref_clk);
      reset <= 1'b0;
      @(posedge ref_clk);
      #1;
      chk("rst_valid_n", 1'b1, memory_cycle_valid_n);
      chk("rst_cap", 1'b0, capture_valid);
      test_fault();
      test_addr();
      test_no_strobe();
      test_capture();
      chk("strobes", exp_strobes, strobe_count);
      test_reset();
      stop_test();
   end
endmodule : tb_top
